/* File: design/debug_breakpoint_pkg.sv */
// Package for the debug breakpoint unit: register layouts, reset values, codes.
// Assumes one core clock domain; all structs travel between core and unit.
package debug_breakpoint_pkg;

  // Debug register slot indices carried by move-to/from-debug-register
  localparam logic [2:0] SLOT_BP0       = 3'h0;
  localparam logic [2:0] SLOT_RSVD_A    = 3'h4;
  localparam logic [2:0] SLOT_RSVD_B    = 3'h5;
  localparam logic [2:0] SLOT_STATUS    = 3'h6;
  localparam logic [2:0] SLOT_CONTROL   = 3'h7;

  // Model-specific register selectors
  localparam logic [2:0] MSR_FEATURE    = 3'h0;
  localparam logic [2:0] MSR_BR_SOURCE  = 3'h1;
  localparam logic [2:0] MSR_BR_TARGET  = 3'h2;
  localparam logic [2:0] MSR_EX_SOURCE  = 3'h3;
  localparam logic [2:0] MSR_EX_TARGET  = 3'h4;

  // Status fields
  localparam int         STS_ACCESS_BIT = 13;
  localparam int         STS_STEP_BIT   = 14;
  localparam int         STS_TASK_BIT   = 15;
  localparam logic [31:0] STS_LIVE_MASK = 32'h0000_e00f;
  localparam logic [31:0] STS_RESET     = 32'hffff_0ff0;

  // Control fields
  localparam int         CTL_GD_BIT     = 13;
  localparam int         CTL_RW_LSB     = 16;
  localparam int         CTL_LEN_LSB    = 18;
  localparam int         CTL_BP_STRIDE  = 4;
  localparam logic [31:0] CTL_LOCAL_MASK = 32'h0000_0055;
  localparam logic [31:0] CTL_RESET     = 32'h0000_0000;

  // Feature control fields
  localparam int         FEAT_RECORD_BIT = 0;
  localparam int         FEAT_BRTRAP_BIT = 1;
  localparam int         FEAT_PINS_LSB   = 2;
  localparam int         FEAT_TRACE_BIT  = 6;
  localparam logic [31:0] FEAT_RESET     = 32'h0000_0000;
  localparam logic [31:0] BP_ADDR_RESET  = 32'h0000_0000;

  // Access type field and access kinds
  typedef enum logic [1:0] {
    RW_EXEC  = 2'b00,
    RW_WRITE = 2'b01,
    RW_IO    = 2'b10,
    RW_DATA  = 2'b11
  } rw_code_e;

  typedef enum logic [1:0] {
    ACC_EXEC  = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_IO    = 2'b10,
    ACC_READ  = 2'b11
  } access_kind_e;

  // Length codes: 00 one byte, 01 two, 11 four, 10 undefined
  localparam logic [1:0] LEN_UNDEF = 2'b10;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  slot;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic         valid;
    access_kind_e kind;
    logic [1:0]   size;
    logic [31:0]  addr;
    logic         resume;
  } mem_access_s;

  typedef struct packed {
    logic        valid;
    logic        step_trap;
    logic        taken_branch;
    logic [31:0] source;
    logic [31:0] target;
  } retire_s;

  typedef struct packed {
    logic        real_mode;
    logic        sys_mgmt;
    logic [1:0]  privilege;
    logic        debug_ext;
  } cpu_mode_s;

endpackage : debug_breakpoint_pkg

/* File: design/debug_breakpoint_unit.sv */
// Breakpoint, debug status and branch recording unit of the core.
// Assumes all inputs come from core pipeline logic on the same clock.
`timescale 1ns/10ps
module debug_breakpoint_unit
  import debug_breakpoint_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  // Processor mode
  input  wire cpu_mode_s   i_mode,
  // Debug register moves
  input  wire reg_req_s    i_reg_req,
  // Model-specific register accesses
  input  wire logic        i_msr_valid,
  input  wire logic        i_msr_write,
  input  wire logic [2:0]  i_msr_sel,
  input  wire logic [31:0] i_msr_wdata,
  // Pipeline events
  input  wire mem_access_s i_access,
  input  wire retire_s     i_retire,
  input  wire logic        i_task_switch,
  input  wire logic        i_task_trap,
  input  wire logic        i_trap_instr,
  input  wire logic        i_except_taken,
  input  wire logic [31:0] i_except_source,
  input  wire logic [31:0] i_except_target,
  // Responses
  output logic             o_resp_valid,
  output logic [31:0]      o_resp_rdata,
  output logic             o_gp_fault,
  output logic             o_ud_fault,
  // Exceptions and pins
  output logic             o_debug_exception,
  output logic             o_breakpoint_exception,
  output logic [3:0]       o_bp_pins,
  output logic             o_trace_msg
);

  // Software-visible registers
  logic [31:0] bp_addr_r [4];
  logic [31:0] bp_addr_nxt [4];
  logic [31:0] status_r, status_nxt;
  logic [31:0] control_r, control_nxt;
  logic [31:0] feature_r, feature_nxt;
  // Branch records
  logic [31:0] br_src_r, br_src_nxt;
  logic [31:0] br_tgt_r, br_tgt_nxt;
  logic [31:0] ex_src_r, ex_src_nxt;
  logic [31:0] ex_tgt_r, ex_tgt_nxt;
  // Answers, exception pulses and pins
  logic        resp_valid_r, resp_valid_nxt;
  logic [31:0] resp_rdata_r, resp_rdata_nxt;
  logic        gp_r, gp_nxt;
  logic        ud_r, ud_nxt;
  logic        dbg_exc_r, dbg_exc_nxt;
  logic        bp_exc_r, bp_exc_nxt;
  logic [3:0]  pins_r, pins_nxt;
  logic        trace_r, trace_nxt;

  logic [3:0]  cond_hit;
  logic [3:0]  enabled_hit;
  logic [31:0] sts_set;
  logic        sw_status_wr;
  logic [31:0] sw_status_val;

  // True when any byte of the access falls in the breakpoint's range
  function automatic logic bp_match(input logic [31:0] bp_addr,
                                    input logic [1:0]  rw,
                                    input logic [1:0]  len,
                                    input logic        dext,
                                    input mem_access_s acc);
    logic        kind_ok;
    logic [32:0] bp_lo;
    logic [32:0] bp_hi;
    logic [32:0] acc_lo;
    logic [32:0] acc_hi;
    logic [31:0] mask;
    logic [31:0] addr;
    kind_ok = 1'b0;
    unique case (rw)
      RW_EXEC:  kind_ok = (acc.kind == ACC_EXEC);
      RW_WRITE: kind_ok = (acc.kind == ACC_WRITE);
      RW_IO:    kind_ok = dext && (acc.kind == ACC_IO);
      RW_DATA:  kind_ok = (acc.kind == ACC_WRITE) || (acc.kind == ACC_READ);
    endcase
    // Port numbers are only 16 bits wide
    addr = (acc.kind == ACC_IO) ? {16'h0000, acc.addr[15:0]} : acc.addr;
    mask = {30'h0000_0000, len[1] & len[0], len[0]};
    bp_lo = {1'b0, bp_addr & ~mask};
    bp_hi = bp_lo + {1'b0, mask} + 33'h0_0000_0001;
    acc_lo = {1'b0, addr};
    acc_hi = acc_lo + {31'h0000_0000, acc.size[1] & acc.size[0], acc.size[0]}
             + 33'h0_0000_0001;
    // Undefined length never matches, so a misprogrammed field stays quiet
    bp_match = acc.valid && kind_ok && (len != LEN_UNDEF) &&
               (acc_lo < bp_hi) && (bp_lo < acc_hi);
  endfunction : bp_match

  // Four comparators side by side
  for (genvar g = 0; g < 4; g++) begin : g_cmp
    always_comb begin
      cond_hit[g] = bp_match(bp_addr_r[g],
                             control_r[CTL_RW_LSB + g*CTL_BP_STRIDE +: 2],
                             control_r[CTL_LEN_LSB + g*CTL_BP_STRIDE +: 2],
                             i_mode.debug_ext, i_access);
      // Resume flag hides execute hits on the restarted instruction
      enabled_hit[g] = cond_hit[g] && |control_r[2*g +: 2] &&
                       !(i_access.kind == ACC_EXEC && i_access.resume);
    end
  end

  always_comb begin
    logic        priv_ok;
    logic        gd_trap;
    logic        step_hit;
    logic        task_hit;
    logic        any_exc;
    logic [2:0]  slot;
    priv_ok       = 1'b0;
    gd_trap       = 1'b0;
    step_hit      = 1'b0;
    task_hit      = 1'b0;
    any_exc       = 1'b0;
    slot          = i_reg_req.slot;
    sts_set       = 32'h0000_0000;
    sw_status_wr  = 1'b0;
    sw_status_val = 32'h0000_0000;

    for (int i = 0; i < 4; i++) begin
      bp_addr_nxt[i] = bp_addr_r[i];
    end
    control_nxt    = control_r;
    feature_nxt    = feature_r;
    resp_valid_nxt = 1'b0;
    resp_rdata_nxt = resp_rdata_r;
    gp_nxt         = 1'b0;
    ud_nxt         = 1'b0;

    priv_ok = i_mode.real_mode || i_mode.sys_mgmt ||
              (i_mode.privilege == 2'b00);

    // Debug register moves
    if (i_reg_req.valid) begin
      if (!priv_ok) begin
        gp_nxt = 1'b1;
      end else if (control_r[CTL_GD_BIT]) begin
        gd_trap = 1'b1;
      end else if ((slot == SLOT_RSVD_A || slot == SLOT_RSVD_B) &&
                   i_mode.debug_ext) begin
        ud_nxt = 1'b1;
      end else begin
        resp_valid_nxt = 1'b1;
        // Aliasing keeps older software that used the low slots working
        if (slot == SLOT_RSVD_A) begin
          slot = SLOT_STATUS;
        end else if (slot == SLOT_RSVD_B) begin
          slot = SLOT_CONTROL;
        end
        if (slot == SLOT_STATUS) begin
          resp_rdata_nxt = status_r;
          sw_status_wr   = i_reg_req.write;
          sw_status_val  = i_reg_req.wdata;
        end else if (slot == SLOT_CONTROL) begin
          resp_rdata_nxt = control_r;
          if (i_reg_req.write) begin
            control_nxt = i_reg_req.wdata;
          end
        end else begin
          resp_rdata_nxt = bp_addr_r[slot[1:0]];
          if (i_reg_req.write) begin
            bp_addr_nxt[slot[1:0]] = i_reg_req.wdata;
          end
        end
      end
    end

    // Model-specific registers
    if (i_msr_valid) begin
      if (!priv_ok) begin
        gp_nxt = 1'b1;
      end else begin
        resp_valid_nxt = 1'b1;
        unique case (i_msr_sel)
          MSR_FEATURE: begin
            resp_rdata_nxt = feature_r;
            if (i_msr_write) begin
              feature_nxt = i_msr_wdata;
            end
          end
          MSR_BR_SOURCE: resp_rdata_nxt = br_src_r;
          MSR_BR_TARGET: resp_rdata_nxt = br_tgt_r;
          MSR_EX_SOURCE: resp_rdata_nxt = ex_src_r;
          MSR_EX_TARGET: resp_rdata_nxt = ex_tgt_r;
          default:       resp_rdata_nxt = 32'h0000_0000;
        endcase
      end
    end

    // Single step, optionally only on taken branches
    step_hit = i_retire.valid && i_retire.step_trap &&
               (!feature_r[FEAT_BRTRAP_BIT] || i_retire.taken_branch);
    task_hit = i_task_switch && i_task_trap;
    any_exc  = step_hit || task_hit || gd_trap || |enabled_hit;

    // Captured conditions, only when an exception is raised
    if (any_exc) begin
      sts_set[3:0]           = cond_hit;
      sts_set[STS_ACCESS_BIT] = gd_trap;
      sts_set[STS_STEP_BIT]   = step_hit;
      sts_set[STS_TASK_BIT]   = task_hit;
      control_nxt[CTL_GD_BIT] = 1'b0;
    end
    if (i_task_switch) begin
      control_nxt = control_nxt & ~CTL_LOCAL_MASK;
    end

    // Raised at the same edge that captures the status bits
    dbg_exc_nxt = any_exc;
  end

  // Status: reserved bits keep their reset pattern whatever is written
  always_comb begin
    status_nxt = status_r;
    if (sw_status_wr) begin
      status_nxt = (sw_status_val & STS_LIVE_MASK) | (STS_RESET & ~STS_LIVE_MASK);
    end
    // Hardware only ORs bits in; a set beats a same-cycle software write
    status_nxt = status_nxt | sts_set;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < 4; i++) begin
        bp_addr_r[i] <= BP_ADDR_RESET;
      end
      status_r  <= STS_RESET;
      control_r <= CTL_RESET;
      feature_r <= FEAT_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        bp_addr_r[i] <= bp_addr_nxt[i];
      end
      status_r  <= status_nxt;
      control_r <= control_nxt;
      feature_r <= feature_nxt;
    end
  end

  // Move and model-specific register answers
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      resp_valid_r <= 1'b0;
      resp_rdata_r <= 32'h0000_0000;
      gp_r         <= 1'b0;
      ud_r         <= 1'b0;
    end else begin
      resp_valid_r <= resp_valid_nxt;
      resp_rdata_r <= resp_rdata_nxt;
      gp_r         <= gp_nxt;
      ud_r         <= ud_nxt;
    end
  end

  // Debug exception pulse
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dbg_exc_r <= 1'b0;
    end else begin
      dbg_exc_r <= dbg_exc_nxt;
    end
  end

  // Breakpoint instruction is ungated and leaves status alone
  always_comb begin
    bp_exc_nxt = i_trap_instr;
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bp_exc_r <= 1'b0;
    end else begin
      bp_exc_r <= bp_exc_nxt;
    end
  end

  // Pins show raw conditions, so disabled breakpoints still report
  always_comb begin
    pins_nxt = cond_hit & feature_r[FEAT_PINS_LSB +: 4];
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pins_r <= 4'h0;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  // Branch recording; pre-exception pair snapshots the last branch first
  always_comb begin
    br_src_nxt = br_src_r;
    br_tgt_nxt = br_tgt_r;
    ex_src_nxt = ex_src_r;
    ex_tgt_nxt = ex_tgt_r;
    if (feature_r[FEAT_RECORD_BIT]) begin
      if (i_except_taken) begin
        ex_src_nxt = br_src_r;
        ex_tgt_nxt = br_tgt_r;
        br_src_nxt = i_except_source;
        br_tgt_nxt = i_except_target;
      end else if (i_retire.valid && i_retire.taken_branch) begin
        br_src_nxt = i_retire.source;
        br_tgt_nxt = i_retire.target;
      end
    end
    trace_nxt = feature_r[FEAT_TRACE_BIT] &&
                ((i_retire.valid && i_retire.taken_branch) || i_except_taken);
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      br_src_r <= 32'h0000_0000;
      br_tgt_r <= 32'h0000_0000;
      ex_src_r <= 32'h0000_0000;
      ex_tgt_r <= 32'h0000_0000;
      trace_r  <= 1'b0;
    end else begin
      br_src_r <= br_src_nxt;
      br_tgt_r <= br_tgt_nxt;
      ex_src_r <= ex_src_nxt;
      ex_tgt_r <= ex_tgt_nxt;
      trace_r  <= trace_nxt;
    end
  end

  assign o_resp_valid           = resp_valid_r;
  assign o_resp_rdata           = resp_rdata_r;
  assign o_gp_fault             = gp_r;
  assign o_ud_fault             = ud_r;
  assign o_debug_exception      = dbg_exc_r;
  assign o_breakpoint_exception = bp_exc_r;
  assign o_bp_pins              = pins_r;
  assign o_trace_msg            = trace_r;

endmodule : debug_breakpoint_unit

/* File: tb/core_pipe_model.sv */
// Core pipeline stand-in: issues memory accesses and retirements.
// Assumes one calling process; each task ends just after a clock edge.
`timescale 1ns/10ps
module core_pipe_model
  import debug_breakpoint_pkg::*;
(
  // Clock
  input  wire logic   i_clk_sys,
  // Pipeline events
  output mem_access_s o_access,
  output retire_s     o_retire
);
  initial begin
    o_access = '0;
    o_retire = '0;
  end

  // Idle cycles carry inverted fields so stale values never match
  task automatic access(input access_kind_e k, input logic [1:0] sz,
                        input logic [31:0] a, input logic res);
    @(posedge i_clk_sys) #1;
    o_access = '{1'b1, k, sz, a, res};
    @(posedge i_clk_sys) #1;
    o_access = '{1'b0, k, ~sz, ~a, ~res};
  endtask : access

  task automatic retire(input logic st, input logic br,
                        input logic [31:0] s, input logic [31:0] t);
    @(posedge i_clk_sys) #1;
    o_retire = '{1'b1, st, br, s, t};
    @(posedge i_clk_sys) #1;
    o_retire = '{1'b0, 1'b0, 1'b0, ~s, ~t};
  endtask : retire
endmodule : core_pipe_model

/* File: tb/debug_breakpoint_unit_assertions.sv */
// Port checker for the debug breakpoint unit.
// Assumes the single core clock and the active-low asynchronous reset.
`timescale 1ns/10ps
module debug_breakpoint_checker
  import debug_breakpoint_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  // Requests and events
  input  wire cpu_mode_s   i_mode,
  input  wire reg_req_s    i_reg_req,
  input  wire logic        i_msr_valid,
  input  wire logic        i_msr_write,
  input  wire logic [2:0]  i_msr_sel,
  input  wire logic [31:0] i_msr_wdata,
  input  wire mem_access_s i_access,
  input  wire retire_s     i_retire,
  input  wire logic        i_task_switch,
  input  wire logic        i_task_trap,
  input  wire logic        i_trap_instr,
  // Answers
  input  wire logic        o_resp_valid,
  input  wire logic        o_gp_fault,
  input  wire logic        o_ud_fault,
  input  wire logic        o_debug_exception,
  input  wire logic        o_breakpoint_exception
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  // Mirror of the branch-only step setting from accepted feature writes
  logic step_on_branch_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      step_on_branch_r <= 1'b0;
    end else if (i_msr_valid && i_msr_write && i_msr_sel == MSR_FEATURE &&
                 (i_mode.real_mode || i_mode.sys_mgmt || i_mode.privilege == 2'h0)) begin
      step_on_branch_r <= i_msr_wdata[FEAT_BRTRAP_BIT];
    end
  end

  sequence s_move_ok;
    i_reg_req.valid && (i_mode.real_mode || i_mode.sys_mgmt || i_mode.privilege == 2'h0);
  endsequence
  sequence s_rsvd;
    s_move_ok ##0 (i_reg_req.slot == SLOT_RSVD_A || i_reg_req.slot == SLOT_RSVD_B);
  endsequence

  property p_gp;
    i_reg_req.valid && !(i_mode.real_mode || i_mode.sys_mgmt) && i_mode.privilege != 2'h0
      |=> o_gp_fault && !o_resp_valid;
  endproperty
  a_gp: assert property (p_gp) else $error("privilege fault missing");
  property p_inv;
    s_rsvd ##0 i_mode.debug_ext |=> !o_resp_valid && (o_ud_fault || o_debug_exception);
  endproperty
  a_inv: assert property (p_inv) else $error("reserved slot not refused");
  property p_alias;
    s_rsvd ##0 !i_mode.debug_ext |=> !o_ud_fault && !o_gp_fault;
  endproperty
  a_alias: assert property (p_alias) else $error("alias slot refused");
  property p_answer;
    i_reg_req.valid |=> $countones({o_resp_valid, o_gp_fault, o_ud_fault}) == 1 ||
      (o_debug_exception && !o_resp_valid && !o_gp_fault && !o_ud_fault);
  endproperty
  a_answer: assert property (p_answer) else $error("move answer wrong");
  property p_step;
    i_retire.valid && i_retire.step_trap && (!step_on_branch_r || i_retire.taken_branch)
      |=> o_debug_exception;
  endproperty
  a_step: assert property (p_step) else $error("step trap missing");
  property p_task;
    i_task_switch && i_task_trap |=> o_debug_exception;
  endproperty
  a_task: assert property (p_task) else $error("task trap missing");
  property p_brk;
    if (i_trap_instr) ##1 o_breakpoint_exception else ##1 !o_breakpoint_exception;
  endproperty
  a_brk: assert property (p_brk) else $error("breakpoint exception wrong");
  property p_no_cause;
    !(i_access.valid || i_retire.valid || i_task_switch || i_reg_req.valid)
      |=> !o_debug_exception;
  endproperty
  a_no_cause: assert property (p_no_cause) else $error("debug exception uncaused");
endmodule : debug_breakpoint_checker

bind debug_breakpoint_unit debug_breakpoint_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_mode(i_mode), .i_reg_req(i_reg_req),
  .i_msr_valid(i_msr_valid), .i_msr_write(i_msr_write), .i_msr_sel(i_msr_sel),
  .i_msr_wdata(i_msr_wdata), .i_access(i_access), .i_retire(i_retire),
  .i_task_switch(i_task_switch), .i_task_trap(i_task_trap), .i_trap_instr(i_trap_instr),
  .o_resp_valid(o_resp_valid), .o_gp_fault(o_gp_fault), .o_ud_fault(o_ud_fault),
  .o_debug_exception(o_debug_exception), .o_breakpoint_exception(o_breakpoint_exception)
);

/* File: tb/debug_breakpoint_unit_bench.sv */
// Bench for the debug breakpoint unit: moves, hits, step, task, branches.
// Assumes the pipeline model drives accesses; all outputs one cycle late.
`timescale 1ns/10ps
module debug_breakpoint_unit_bench
  import debug_breakpoint_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  cpu_mode_s   mode = '0;
  reg_req_s    req = '0;
  logic        msr_v = 1'b0;
  logic        msr_w = 1'b0;
  logic [2:0]  msr_s = '0;
  logic [31:0] msr_d = '0;
  logic        tsw = 1'b0;
  logic        ttrap = 1'b0;
  logic        trap_op = 1'b0;
  logic        exc = 1'b0;
  logic [31:0] exc_src = '0;
  logic [31:0] exc_tgt = '0;
  mem_access_s acc;
  retire_s     ret;
  logic        rv, prot_flt, inv_flt, dbg_x, brk_x;
  logic [31:0] rdata;
  logic [3:0]  pins;
  logic        trc;
  int          fails = 0;
  int          total_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  core_pipe_model pm (.i_clk_sys(clk_sys), .o_access(acc), .o_retire(ret));
  debug_breakpoint_unit DUT (
    .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_mode(mode), .i_reg_req(req),
    .i_msr_valid(msr_v), .i_msr_write(msr_w), .i_msr_sel(msr_s), .i_msr_wdata(msr_d),
    .i_access(acc), .i_retire(ret), .i_task_switch(tsw), .i_task_trap(ttrap),
    .i_trap_instr(trap_op), .i_except_taken(exc), .i_except_source(exc_src),
    .i_except_target(exc_tgt), .o_resp_valid(rv), .o_resp_rdata(rdata),
    .o_gp_fault(prot_flt), .o_ud_fault(inv_flt), .o_debug_exception(dbg_x),
    .o_breakpoint_exception(brk_x), .o_bp_pins(pins), .o_trace_msg(trc)
  );

  task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask : chkv

  task automatic chkf(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : chkf

  task automatic mv(input logic w, input logic [2:0] s, input logic [31:0] d);
    @(posedge clk_sys) #1;
    req = '{1'b1, w, s, d};
    @(posedge clk_sys) #1;
    req = '{1'b0, 1'b0, s, ~d};
  endtask : mv

  task automatic msr(input logic w, input logic [2:0] s, input logic [31:0] d);
    @(posedge clk_sys) #1;
    {msr_v, msr_w, msr_s, msr_d} = {1'b1, w, s, d};
    @(posedge clk_sys) #1;
    {msr_v, msr_w, msr_d} = {1'b0, 1'b0, ~d};
  endtask : msr

  task automatic pulse(ref logic s);
    @(posedge clk_sys) #1;
    s = 1'b1;
    @(posedge clk_sys) #1;
    s = 1'b0;
  endtask : pulse

  task automatic rdreg(input logic [2:0] s, input logic [31:0] e);
    mv(1'b0, s, '0);
    chkv(rdata, e);
  endtask : rdreg

  task automatic t_priv();
    rdreg(SLOT_STATUS, STS_RESET);
    rdreg(3'h3, BP_ADDR_RESET);
    mode.privilege = 2'h3;
    mv(1'b1, SLOT_BP0, 32'h000a_0001);
    chkf(prot_flt, 1'b1);
    chkf(rv, 1'b0);
    mode.sys_mgmt = 1'b1;
    mv(1'b1, SLOT_BP0, 32'h000a_0001);
    chkf(rv, 1'b1);
    mode = '0;
    mv(1'b1, 3'h1, 32'h000a_0002);
    rdreg(SLOT_BP0, 32'h000a_0001);
    mode.debug_ext = 1'b1;
    mv(1'b0, SLOT_RSVD_A, '0);
    chkf(inv_flt, 1'b1);
    mode.debug_ext = 1'b0;
    mv(1'b1, SLOT_RSVD_B, 32'h0013_0001);
    rdreg(SLOT_CONTROL, 32'h0013_0001);
    rdreg(SLOT_RSVD_A, STS_RESET);
    $display("test moves done");
  endtask : t_priv

  task automatic t_hit();
    pm.access(ACC_READ, 2'b00, 32'h000a_0000, 1'b0);
    chkf(dbg_x, 1'b0);
    pm.access(ACC_WRITE, 2'b01, 32'h000a_0001, 1'b0);
    chkf(dbg_x, 1'b1);
    chkv({28'h0000000, pins}, 32'h0);
    repeat (4) @(posedge clk_sys);
    rdreg(SLOT_STATUS, STS_RESET | 32'h3);
    mv(1'b1, SLOT_STATUS, '0);
    mv(1'b1, SLOT_CONTROL, 32'h1);
    pm.access(ACC_EXEC, 2'b00, 32'h000a_0001, 1'b1);
    chkf(dbg_x, 1'b0);
    pm.access(ACC_EXEC, 2'b00, 32'h000a_0001, 1'b0);
    chkf(dbg_x, 1'b1);
    rdreg(SLOT_STATUS, STS_RESET | 32'h1);
    mv(1'b1, SLOT_STATUS, '0);
    $display("test breakpoints done");
  endtask : t_hit

  task automatic t_events();
    pm.retire(1'b1, 1'b0, '0, '0);
    chkf(dbg_x, 1'b1);
    rdreg(SLOT_STATUS, STS_RESET | 32'h4000);
    mv(1'b1, SLOT_STATUS, '0);
    mv(1'b1, SLOT_CONTROL, 32'h9);
    ttrap = 1'b1;
    pulse(tsw);
    ttrap = 1'b0;
    chkf(dbg_x, 1'b1);
    rdreg(SLOT_STATUS, STS_RESET | 32'h8000);
    rdreg(SLOT_CONTROL, 32'h8);
    mv(1'b1, SLOT_STATUS, '0);
    mv(1'b1, SLOT_CONTROL, 32'h2000);
    mv(1'b0, SLOT_BP0, '0);
    chkf(dbg_x, 1'b1);
    chkf(rv, 1'b0);
    rdreg(SLOT_STATUS, STS_RESET | 32'h2000);
    rdreg(SLOT_CONTROL, 32'h0);
    pulse(trap_op);
    chkf(brk_x, 1'b1);
    $display("test events done");
  endtask : t_events

  task automatic t_branch();
    logic [31:0] exp [4] = '{32'h300, 32'h400, 32'h100, 32'h200};
    msr(1'b1, MSR_FEATURE, 32'h7d);
    msr(1'b0, MSR_FEATURE, '0);
    chkv(rdata, 32'h7d);
    pm.retire(1'b0, 1'b1, 32'h100, 32'h200);
    chkf(trc, 1'b1);
    exc_src = 32'h300;
    exc_tgt = 32'h400;
    pulse(exc);
    chkf(trc, 1'b1);
    pm.access(ACC_EXEC, 2'b00, 32'h000a_0001, 1'b0);
    chkv({28'h0000000, pins}, 32'h1);
    chkf(dbg_x, 1'b0);
    chkf(trc, 1'b0);
    for (int i = 0; i < 4; i++) begin
      msr(1'b0, 3'(i + 1), '0);
      chkv(rdata, exp[i]);
    end
    $display("test branch records done");
  endtask : t_branch

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Whole run is under a hundred cycles; this leaves wide margin
  initial begin
    #50us;
    fails++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    t_priv();
    t_hit();
    t_events();
    t_branch();
    print_verdict();
  end
endmodule : debug_breakpoint_unit_bench
